// file: src/mux_pkg.sv
/*
  Shared constants and types for the terminal multiplexer connect and fan-in logic.
  Assumes a single 50 MHz clock and a 32-bit classic Wishbone register bus.
*/
package mux_pkg;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int CLK_HZ = 50_000_000;
  // Just under a 100 ms character interval
  localparam int INT_PERIOD_US = 90_000;
  localparam int INT_PERIOD_CYC = INT_PERIOD_US * (CLK_HZ / 1_000_000);

  // ********************************************************************
  // Word and unit geometry
  // ********************************************************************
  localparam int WORD_W = 12;
  localparam int CHAR_W = 8;
  localparam int UNIT_W = 3;
  localparam int UNITS = 16;
  localparam int IDX_W = 4;
  localparam int BIT_READY = 11;
  localparam int BIT_LOST = 10;
  localparam int BIT_BRK_IDLE = 9;
  localparam int BIT_REQ = 8;
  localparam int CODE_MATCH_HI = 11;
  localparam int CODE_MATCH_LO = 4;
  localparam int CODE_SECTION = 3;
  localparam int MATCH_W = 8;

  // ********************************************************************
  // Register map
  // ********************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_MATCH = 8'h04;
  localparam logic [7:0] REG_PERIOD = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam int CTRL_SCAN = 0;
  localparam logic CTRL_SCAN_RST = 1'b0;
  localparam logic [MATCH_W-1:0] MATCH_RST = 8'h00;
  localparam int ST_CONN = 0;
  localparam int ST_SECT = 1;
  localparam int ST_UNIT = 2;
  localparam int ST_LOCK = 5;
  localparam int ST_IRQ = 6;
  localparam int ST_READ = 7;
  localparam int ST_WRITE = 8;

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef struct packed {
    logic ready;
    logic lost;
    logic brk;
    logic idle;
  } unit_status_s;

  typedef struct packed {
    logic [1:0] conn_sy, rd_sy, wr_sy, strb_sy, cil_sy, clr_sy;
    logic [WORD_W-1:0] din_sy1, din_sy2;
    logic conn_d, strb_d, cil_d;
    logic [31:0] tick_cnt, period;
    logic scan_en;
    logic [MATCH_W-1:0] match;
    logic irq_flag, lockout, irq_out;
    logic connected, section;
    logic [UNIT_W-1:0] unit;
    logic reply, rd_pend, rd_took;
    logic [WORD_W-1:0] dout;
    logic dout_oe;
    logic [UNITS-1:0] iack;
    logic [CHAR_W-1:0] ochar;
    logic ostrobe;
    logic wb_ack;
    logic [31:0] wb_dat;
  } state_s;

endpackage

// file: src/input_fan_in.sv
/*
  Fan-in of character data and status from the serial input units onto one word.
  Assumes unit outputs are logic on the same clock; output is combinational.
*/
`timescale 1ns/1ns
`default_nettype none

module input_fan_in
  import mux_pkg::*;
#(
  parameter int UNITS_P = UNITS
) (
  // Unit side
  input wire logic [UNITS_P*CHAR_W-1:0] char_i,
  input wire unit_status_s [UNITS_P-1:0] status_i,
  input wire logic [UNITS_P-1:0] req_i,
  // Selection
  input wire logic [IDX_W-1:0] sel_i,
  input wire logic en_i,
  // Shared word
  output logic [WORD_W-1:0] word_o
);

  unit_status_s st;

  // ********************************************************************
  // One shared group, only the selected unit reaches it
  // ********************************************************************
  always_comb begin
    st = status_i[sel_i];
    word_o = '0;
    if (en_i) begin
      word_o[BIT_READY] = st.ready;
      word_o[BIT_LOST] = st.lost;
      word_o[BIT_BRK_IDLE] = st.brk | st.idle;
      word_o[BIT_REQ] = req_i[sel_i];
      // Idle keeps the unit's held character; break forces zero
      if (!st.brk) begin
        word_o[CHAR_W-1:0] = char_i[sel_i*CHAR_W +: CHAR_W];
      end
    end
  end

endmodule

`default_nettype wire

// file: src/terminal_mux_connect_fanin.sv
/*
  Computer-facing connect decoder, interrupt clock and input fan-in of the terminal
  multiplexer, with a classic Wishbone register slave.
  Assumes host channel pins are asynchronous, unit signals share clk_i.
*/
// The Wishbone interface to the registers and the register addresses were left to the implementer.
// Function
// - Interrupt flip-flop set once per free-running interrupt clock cycle.
// - Interrupt period is programmable, just under the character interval.
// - Data words are 12 bits, at most eight carry character data.
// - First two code digits select the group of cabinets.
// - Third digit upper bits select cabinet, lowest bit the section.
// - Fourth digit selects one of eight unit pairs, 0 to 7.
// - Connect accepted only when upper code matches wired setting.
// - Section A on even third digit, section B on odd.
// - Scanning variant steps through input units itself in read mode.
// - Each status signal fanned in so only connected unit shows.
// - Character ready presented on data bit 11 with the character.
// - After acceptance a short acknowledge clears only the selected unit.
// - Character lost raised toward host when a character was missed.
// - Character presented as zeros while break is set.
// - Idle status after 5 s marking; last character repeats.
// - Idle and break merged onto one status line.
// - All units share one data group, one driver at a time.
// - Reply follows connect or data strobe and drops with it.
// - Read character placed on low data bits before reply.
`timescale 1ns/1ns
`default_nettype none

module terminal_mux_connect_fanin
  import mux_pkg::*;
#(
  parameter int INT_PERIOD_P = INT_PERIOD_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Host channel
  input wire logic [WORD_W-1:0] host_data_i,
  output logic [WORD_W-1:0] host_data_o,
  output logic host_data_oe_o,
  input wire logic connect_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic data_strobe_i,
  input wire logic clear_interrupt_lockout_i,
  input wire logic interrupt_clear_i,
  output logic reply_o,
  output logic interrupt_o,
  // Serial unit side
  input wire logic [UNITS*CHAR_W-1:0] unit_char_i,
  input wire unit_status_s [UNITS-1:0] unit_status_i,
  input wire logic [UNITS-1:0] char_request_i,
  output logic [UNITS-1:0] input_ack_o,
  output logic unit_connected_o,
  output logic unit_section_o,
  output logic [UNIT_W-1:0] unit_index_o,
  output logic [CHAR_W-1:0] out_char_o,
  output logic out_strobe_o
);

  // ********************************************************************
  // Helpers
  // ********************************************************************
  function automatic logic [UNITS-1:0] unit_onehot(input logic [IDX_W-1:0] i);
    unit_onehot = '0;
    unit_onehot[i] = 1'b1;
  endfunction

  function automatic logic [31:0] byte_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
    byte_merge = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        byte_merge[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
  endfunction

  state_s s_reg;
  state_s s_next;
  logic [WORD_W-1:0] fan_word;
  logic [IDX_W-1:0] idx;
  logic tick;
  logic conn_rise;
  logic strb_rise;
  logic cil_rise;
  logic code_ok;
  logic scan_idle;
  logic wb_hit;
  logic fan_brk;

  assign idx = {s_reg.section, s_reg.unit};
  assign fan_brk = unit_status_i[idx].brk;
  assign conn_rise = s_reg.conn_sy[1] & ~s_reg.conn_d;
  assign strb_rise = s_reg.strb_sy[1] & ~s_reg.strb_d;
  assign cil_rise = s_reg.cil_sy[1] & ~s_reg.cil_d;
  // Short periods collapse to one cycle rather than stalling
  assign tick = (s_reg.period <= 32'h0000_0001) || (s_reg.tick_cnt >= s_reg.period - 32'h1);
  assign code_ok = s_reg.din_sy2[CODE_MATCH_HI:CODE_MATCH_LO] == s_reg.match;
  // A connect in flight wins over the scanner, so the new code is kept
  assign scan_idle = s_reg.scan_en & s_reg.connected & s_reg.rd_sy[1] & ~s_reg.strb_sy[1]
                     & ~s_reg.conn_sy[1] & ~s_reg.reply & ~s_reg.rd_pend & ~s_reg.rd_took;
  assign wb_hit = wb_cyc_i & wb_stb_i & ~s_reg.wb_ack;

  input_fan_in #(
    .UNITS_P(UNITS)
  ) u_fan_in (
    .char_i(unit_char_i),
    .status_i(unit_status_i),
    .req_i(char_request_i),
    .sel_i(idx),
    .en_i(s_reg.connected),
    .word_o(fan_word)
  );

  // ********************************************************************
  // Next state
  // ********************************************************************
  always_comb begin
    s_next = s_reg;
    // Two-flop synchronisers on every host pin
    s_next.conn_sy = {s_reg.conn_sy[0], connect_i};
    s_next.rd_sy = {s_reg.rd_sy[0], read_i};
    s_next.wr_sy = {s_reg.wr_sy[0], write_i};
    s_next.strb_sy = {s_reg.strb_sy[0], data_strobe_i};
    s_next.cil_sy = {s_reg.cil_sy[0], clear_interrupt_lockout_i};
    s_next.clr_sy = {s_reg.clr_sy[0], interrupt_clear_i};
    s_next.din_sy1 = host_data_i;
    s_next.din_sy2 = s_reg.din_sy1;
    s_next.conn_d = s_reg.conn_sy[1];
    s_next.strb_d = s_reg.strb_sy[1];
    s_next.cil_d = s_reg.cil_sy[1];
    s_next.iack = '0;
    s_next.ostrobe = 1'b0;
    s_next.wb_ack = 1'b0;

    // Interrupt clock runs free; only the host removes the request
    if (s_reg.clr_sy[1]) begin
      s_next.irq_flag = 1'b0;
    end
    if (tick) begin
      s_next.tick_cnt = '0;
      s_next.irq_flag = 1'b1;
    end else begin
      s_next.tick_cnt = s_reg.tick_cnt + 32'h1;
    end
    if (cil_rise) begin
      s_next.lockout = 1'b0;
    end
    s_next.irq_out = s_reg.irq_flag & ~s_reg.lockout;

    // Connect decode
    if (conn_rise) begin
      if (code_ok) begin
        s_next.connected = 1'b1;
        s_next.section = s_reg.din_sy2[CODE_SECTION];
        s_next.unit = s_reg.din_sy2[UNIT_W-1:0];
        s_next.reply = 1'b1;
        s_next.lockout = 1'b1;
      end else begin
        // Another cabinet addressed: drop off the shared lines
        s_next.connected = 1'b0;
        s_next.dout = '0;
        s_next.dout_oe = 1'b0;
      end
    end

    // Data strobe
    if (strb_rise && s_reg.connected) begin
      if (s_reg.rd_sy[1]) begin
        s_next.dout = fan_word;
        s_next.dout_oe = 1'b1;
        s_next.rd_pend = 1'b1;
        s_next.rd_took = fan_word[BIT_READY];
      end else if (s_reg.wr_sy[1]) begin
        s_next.ochar = s_reg.din_sy2[CHAR_W-1:0];
        s_next.ostrobe = 1'b1;
        s_next.reply = 1'b1;
      end
    end
    // Word stands one cycle before reply
    if (s_reg.rd_pend) begin
      s_next.rd_pend = 1'b0;
      s_next.reply = 1'b1;
    end

    // Release: reply falls, accepted character acknowledged
    if (!s_reg.conn_sy[1] && !s_reg.strb_sy[1] && !s_reg.rd_pend) begin
      s_next.reply = 1'b0;
      s_next.dout_oe = 1'b0;
      s_next.dout = '0;
      s_next.rd_took = 1'b0;
      if (s_reg.rd_took) begin
        s_next.iack = unit_onehot(idx);
        if (s_reg.scan_en) begin
          {s_next.section, s_next.unit} = idx + 4'h1;
        end
      end
    end

    // Scanner skips units without a character
    if (scan_idle && !fan_word[BIT_READY]) begin
      {s_next.section, s_next.unit} = idx + 4'h1;
    end

    // Wishbone slave, one wait state
    if (wb_hit) begin
      s_next.wb_ack = 1'b1;
      s_next.wb_dat = '0;
      if (wb_we_i) begin
        case ({wb_adr_i[7:2], 2'b00})
          REG_CTRL: begin
            if (wb_sel_i[0]) begin
              s_next.scan_en = wb_dat_i[CTRL_SCAN];
            end
          end
          REG_MATCH: begin
            if (wb_sel_i[0]) begin
              s_next.match = wb_dat_i[MATCH_W-1:0];
            end
          end
          REG_PERIOD: begin
            s_next.period = byte_merge(s_reg.period, wb_dat_i, wb_sel_i);
          end
          default: begin
          end
        endcase
      end else begin
        case ({wb_adr_i[7:2], 2'b00})
          REG_CTRL: s_next.wb_dat[CTRL_SCAN] = s_reg.scan_en;
          REG_MATCH: s_next.wb_dat[MATCH_W-1:0] = s_reg.match;
          REG_PERIOD: s_next.wb_dat = s_reg.period;
          REG_STATUS: begin
            s_next.wb_dat[ST_CONN] = s_reg.connected;
            s_next.wb_dat[ST_SECT] = s_reg.section;
            s_next.wb_dat[ST_UNIT +: UNIT_W] = s_reg.unit;
            s_next.wb_dat[ST_LOCK] = s_reg.lockout;
            s_next.wb_dat[ST_IRQ] = s_reg.irq_flag;
            s_next.wb_dat[ST_READ] = s_reg.rd_sy[1];
            s_next.wb_dat[ST_WRITE] = s_reg.wr_sy[1];
          end
          default: s_next.wb_dat = '0;
        endcase
      end
    end
  end

  // ********************************************************************
  // State register
  // ********************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
      s_reg.period <= 32'(INT_PERIOD_P);
      s_reg.scan_en <= CTRL_SCAN_RST;
      s_reg.match <= MATCH_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign wb_dat_o = s_reg.wb_dat;
  assign wb_ack_o = s_reg.wb_ack;
  assign host_data_o = s_reg.dout;
  assign host_data_oe_o = s_reg.dout_oe;
  assign reply_o = s_reg.reply;
  assign interrupt_o = s_reg.irq_out;
  assign input_ack_o = s_reg.iack;
  assign unit_connected_o = s_reg.connected;
  assign unit_section_o = s_reg.section;
  assign unit_index_o = s_reg.unit;
  assign out_char_o = s_reg.ochar;
  assign out_strobe_o = s_reg.ostrobe;

  // ********************************************************************
  // Checks
  // ********************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence seq_rd_launch;
    $rose(s_reg.dout_oe);
  endsequence

  sequence seq_rd_reply;
    ##1 (s_reg.reply && s_reg.dout_oe);
  endsequence

  property p_irq_tick;
    tick |=> s_reg.irq_flag;
  endproperty
  a_irq_tick: assert property (p_irq_tick)
    else $error("interrupt flag not set by clock tick");

  property p_lockout_mask;
    s_reg.lockout |=> !s_reg.irq_out;
  endproperty
  a_lockout_mask: assert property (p_lockout_mask)
    else $error("interrupt raised during lockout");

  property p_reject;
    conn_rise && !code_ok |=> !s_reg.connected;
  endproperty
  a_reject: assert property (p_reject)
    else $error("mismatched connect code accepted");

  property p_decode;
    conn_rise && code_ok |=> s_reg.connected && s_reg.reply
      && s_reg.section == $past(s_reg.din_sy2[CODE_SECTION])
      && s_reg.unit == $past(s_reg.din_sy2[UNIT_W-1:0]);
  endproperty
  a_decode: assert property (p_decode)
    else $error("connect code decoded wrongly");

  property p_reply_drop;
    !s_reg.conn_sy[1] && !s_reg.strb_sy[1] && !s_reg.rd_pend |=> !s_reg.reply;
  endproperty
  a_reply_drop: assert property (p_reply_drop)
    else $error("reply held after strobes dropped");

  property p_data_first;
    seq_rd_launch |-> !s_reg.reply ##0 seq_rd_reply;
  endproperty
  a_data_first: assert property (p_data_first)
    else $error("reply not one cycle after read data");

  property p_status_bits;
    seq_rd_launch |-> s_reg.dout[BIT_READY:BIT_BRK_IDLE] == $past(fan_word[BIT_READY:BIT_BRK_IDLE]);
  endproperty
  a_status_bits: assert property (p_status_bits)
    else $error("status bits wrong on read word");

  property p_break_zero;
    seq_rd_launch ##0 $past(fan_brk) |-> s_reg.dout[CHAR_W-1:0] == 8'h00;
  endproperty
  a_break_zero: assert property (p_break_zero)
    else $error("character not zero under break");

  property p_iack_one;
    s_reg.iack != '0 |-> s_reg.iack == unit_onehot($past(idx)) && $past(s_reg.rd_took);
  endproperty
  a_iack_one: assert property (p_iack_one)
    else $error("acknowledge not to selected unit only");

  property p_disc_zero;
    !s_reg.connected |-> s_reg.dout == '0 && !s_reg.dout_oe;
  endproperty
  a_disc_zero: assert property (p_disc_zero)
    else $error("shared lines driven while unconnected");

endmodule

`default_nettype wire

// file: verification/host_model.sv
/*
  Host parallel channel model: connect, data transfer, lockout clear and interrupt clear.
  Assumes the bench resolves the shared data wire and calls these tasks in turn.
*/
`timescale 1ns/1ns
`default_nettype none

module host_model
  import mux_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // From the block
  input wire logic reply_i,
  input wire logic [WORD_W-1:0] data_i,
  input wire logic [UNITS-1:0] iack_i,
  // To the block
  output logic [WORD_W-1:0] data_o,
  output logic connect_o,
  output logic read_o,
  output logic write_o,
  output logic strobe_o,
  output logic cil_o,
  output logic iclr_o
);
  initial begin
    data_o = 12'hFFF;
    connect_o = 1'b0;
    read_o = 1'b0;
    write_o = 1'b0;
    strobe_o = 1'b0;
    cil_o = 1'b0;
    iclr_o = 1'b0;
  end

  // ********************************************************************
  // Handshakes
  // ********************************************************************
  task automatic wait_reply(input logic lvl, output logic ok);
    int n;
    n = 0;
    while (reply_i !== lvl && n < 16) begin
      @(posedge clk_i);
      n++;
    end
    ok = (reply_i === lvl);
  endtask

  // One code per call, lines set three cycles before connect rises
  task automatic connect(input logic [WORD_W-1:0] code, input logic rd, input logic wr,
                         output logic ok);
    logic d;
    @(posedge clk_i);
    data_o <= code;
    read_o <= rd;
    write_o <= wr;
    repeat (3) @(posedge clk_i);
    connect_o <= 1'b1;
    wait_reply(1'b1, ok);
    connect_o <= 1'b0;
    // Released lines never keep the old code
    data_o <= ~code;
    wait_reply(1'b0, d);
  endtask

  // Random lag plays a slow host
  task automatic xfer(input logic [WORD_W-1:0] wd, output logic [WORD_W-1:0] rd_word,
                      output logic [UNITS-1:0] ack, output logic ok);
    repeat ($urandom % 4) @(posedge clk_i);
    @(posedge clk_i);
    data_o <= wd;
    @(posedge clk_i);
    strobe_o <= 1'b1;
    wait_reply(1'b1, ok);
    rd_word = data_i;
    strobe_o <= 1'b0;
    ack = '0;
    repeat (8) begin
      @(posedge clk_i);
      ack |= iack_i;
    end
    data_o <= ~wd;
  endtask

  // Lockout clear or interrupt clear, held high for four cycles
  task automatic pulse(input logic lock);
    @(posedge clk_i);
    if (lock) cil_o <= 1'b1;
    else iclr_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    cil_o <= 1'b0;
    iclr_o <= 1'b0;
  endtask
endmodule

`default_nettype wire

// file: verification/terminal_mux_connect_fanin_bench.sv
/*
  Self-checking bench: registers, interrupt clock, connect decode, fan-in and scan.
  Assumes host_model stands in for the host channel; unit inputs come from here.
*/
`timescale 1ns/1ns
`default_nettype none

module terminal_mux_connect_fanin_bench
  import mux_pkg::*;
;
  localparam int P = 40;
  logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, reply, irq, h_oe, ostb;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel, be;
  logic [31:0] wb_wdat, wb_rdat, wb_q;
  logic [WORD_W-1:0] h_drv, h_out, h_wire;
  logic conn, rd, wr, strb, clear_interrupt_lockout, iclr, u_conn, u_sect;
  logic [UNITS*CHAR_W-1:0] uch;
  unit_status_s [UNITS-1:0] ust;
  logic [UNITS-1:0] ureq, iack;
  logic [UNIT_W-1:0] u_idx;
  logic [CHAR_W-1:0] ochar;
  int n_errors, n_tests, cycles, n_ostb;

  assign h_wire = h_oe ? h_out : h_drv;

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  terminal_mux_connect_fanin #(.INT_PERIOD_P(P)) terminal_mux_connect_fanin_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_q),
    .wb_ack_o(wb_ack), .host_data_i(h_wire), .host_data_o(h_out), .host_data_oe_o(h_oe),
    .connect_i(conn), .read_i(rd), .write_i(wr), .data_strobe_i(strb),
    .clear_interrupt_lockout_i(clear_interrupt_lockout), .interrupt_clear_i(iclr), .reply_o(reply),
    .interrupt_o(irq), .unit_char_i(uch), .unit_status_i(ust), .char_request_i(ureq),
    .input_ack_o(iack), .unit_connected_o(u_conn), .unit_section_o(u_sect),
    .unit_index_o(u_idx), .out_char_o(ochar), .out_strobe_o(ostb));

  host_model host_model_inst (
    .clk_i(clk_i), .reply_i(reply), .data_i(h_wire), .iack_i(iack), .data_o(h_drv),
    .connect_o(conn), .read_o(rd), .write_o(wr), .strobe_o(strb), .cil_o(clear_interrupt_lockout),
    .iclr_o(iclr));

  // ********************************************************************
  // Helpers
  // ********************************************************************
  task automatic end_sim();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_sel <= be;
    wb_adr <= a;
    wb_wdat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    chk(wb_ack, 1);
    wb_rdat = wb_q;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask

  task automatic wait_irq(input logic lvl, input int lim);
    int n;
    n = 0;
    while (irq !== lvl && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    chk(irq, lvl);
  endtask

  // Holds with no clear, then spacing of two rises
  task automatic irq_test(input int p);
    logic hold;
    time t1;
    hold = 1'b1;
    wait_irq(1'b1, 2 * p + 8);
    repeat (2 * p) begin
      @(posedge clk_i);
      hold &= irq;
    end
    chk(hold, 1);
    host_model_inst.pulse(1'b0);
    wait_irq(1'b0, 8);
    wait_irq(1'b1, 2 * p);
    t1 = $time;
    host_model_inst.pulse(1'b0);
    wait_irq(1'b0, 8);
    wait_irq(1'b1, 2 * p);
    chk(32'(($time - t1) / 20), p);
  endtask

  function automatic logic [WORD_W-1:0] exp_word(input int i);
    unit_status_s s;
    s = ust[i];
    return {s.ready, s.lost, s.brk | s.idle, ureq[i], s.brk ? 8'h00 : uch[i*CHAR_W +: CHAR_W]};
  endfunction

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      end_sim();
    end
  end

  // Output strobes counted so a missing or doubled pulse shows
  always @(posedge clk_i) begin
    if (ostb === 1'b1) begin
      n_ostb <= n_ostb + 1;
    end
  end

  // ********************************************************************
  // Sequence
  // ********************************************************************
  initial begin
    logic [7:0] m;
    logic ok;
    logic [WORD_W-1:0] w, v;
    logic [UNITS-1:0] ack;
    unit_status_s [UNITS-1:0] us;
    int t, n;
    void'($urandom(60720));
    {n_errors, n_tests, cycles, n_ostb} = '0;
    {rst_i, wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat, wb_sel} = '0;
    be = 4'hF;
    rst_i = 1'b1;
    uch = '0;
    ust = '0;
    ureq = '0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, REG_CTRL, 0);
    chk(wb_rdat, 0);
    wb(1'b0, REG_PERIOD, 0);
    chk(wb_rdat, P);
    wb(1'b0, REG_STATUS, 0);
    chk(wb_rdat, 0);
    wb(1'b1, 8'h10, 32'h5A5A5A5A);
    wb(1'b0, 8'h10, 0);
    chk(wb_rdat, 0);
    m = 8'($urandom);
    wb(1'b1, REG_MATCH, {24'h0, m});
    wb(1'b0, REG_MATCH, 0);
    chk(wb_rdat, {24'h0, m});
    irq_test(P);
    for (int i = 0; i < UNITS; i++) begin
      @(posedge clk_i);
      uch <= {$urandom, $urandom, $urandom, $urandom};
      us = {$urandom, $urandom};
      if (i == 0) us[0] = 4'h0;
      if (i == UNITS - 1) us[i] = 4'hA;
      ust <= us;
      ureq <= 16'($urandom);
      host_model_inst.connect({m, i[3:0]}, 1'b1, 1'b0, ok);
      chk(ok, 1);
      chk({u_conn, u_sect, u_idx}, {1'b1, i[3:0]});
      chk(irq, 0);
      host_model_inst.xfer(12'h000, w, ack, ok);
      chk(w, exp_word(i));
      chk(ack, ust[i].ready ? 16'(1 << i) : 16'h0);
      host_model_inst.pulse(1'b1);
      wb(1'b0, REG_STATUS, 0);
      chk(wb_rdat[5:0], {1'b0, i[2:0], i[3], 1'b1});
    end
    w = 12'($urandom);
    host_model_inst.connect({m, 4'h5}, 1'b0, 1'b1, ok);
    host_model_inst.xfer(w, v, ack, ok);
    chk(ok, 1);
    chk(ochar, w[7:0]);
    chk(v, w);
    chk(n_ostb, 1);
    host_model_inst.pulse(1'b1);
    host_model_inst.connect({~m, 4'h2}, 1'b1, 1'b0, ok);
    chk({ok, u_conn}, 0);
    host_model_inst.xfer(12'h000, w, ack, ok);
    chk({ok, h_oe, h_out}, 0);
    wb(1'b1, REG_CTRL, 1);
    t = 1 + $urandom % 15;
    @(posedge clk_i);
    us = '0;
    us[t] = 4'h8;
    ust <= us;
    host_model_inst.connect({m, 4'h0}, 1'b1, 1'b0, ok);
    n = 0;
    while ({u_sect, u_idx} !== t[3:0] && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    chk({u_sect, u_idx}, t[3:0]);
    host_model_inst.xfer(12'h000, w, ack, ok);
    chk(w, exp_word(t));
    chk(ack, 16'(1 << t));
    host_model_inst.pulse(1'b1);
    wb(1'b1, REG_CTRL, 0);
    // Byte lane 0 only: upper bytes of the old period stay
    be = 4'h1;
    wb(1'b1, REG_PERIOD, 32'h5A5A_5A18);
    be = 4'hF;
    wb(1'b0, REG_PERIOD, 0);
    chk(wb_rdat, 24);
    irq_test(24);
    end_sim();
  end
endmodule

`default_nettype wire
